// [design/ssp_cfg.svh]
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
// Behaviour
// RULE1: stop code 0: dynamic brake stops motor, then brake is released.
// RULE2: stop code 1: drive removed, motor coasts to a stop.
// RULE3: stop code 2: brake on servo-off, plug braking on overtravel, then coast.
// RULE4: stop code 3: coast on servo-off, plug braking on overtravel, then coast.
// RULE5: stop code 4: brake on servo-off, plug braking on overtravel, then zero clamp.
// RULE6: stop code 5: coast on servo-off, plug braking on overtravel, then zero clamp.
// RULE7: clear code 0: clear position error on servo-off, keep it on overtravel.
// RULE8: clear code 1: never clear the position error.
// RULE9: clear code 2: clear on servo-off or overtravel, not when ending in clamp.
// RULE10: pulse format: sign+pulse, cw+ccw pulses, or quadrature x1, x2, x4.
// RULE11: inversion code 0 keeps input polarity; code 2 inverts both inputs.
// RULE12: feedforward codes 2,3 high-speed; odd codes accept external analog input.
// RULE13: mode 0: analog speed control; mode switch selects PI off, P on.
// RULE14: mode 1: pulse position control; mode switch selects PI off, P on.
// RULE15: mode 2: analog torque control; mode switch ignored.
// RULE16: mode 3: contact speed; all three inputs off gives zero-reference mode.
// RULE17: mode 4: contact speed; all three inputs off gives analog speed.
// RULE18: mode 5: contact speed; all three inputs off gives pulse position.
// RULE19: all configuration codes latch at restart; later writes wait for next restart.
// RULE20: quadrature direction from phase order; both phases changing together is ignored.

`define SSP_ADDR_CFG0   8'h00
`define SSP_ADDR_CFG1   8'h04
`define SSP_ADDR_STATUS 8'h08
`define SSP_ADDR_COUNT  8'h0C

`define SSP_STOP_LSB 0
`define SSP_CLR_LSB  4
`define SSP_FMT_LSB  8
`define SSP_INV_LSB  12
`define SSP_FF_LSB   0
`define SSP_MODE_LSB 4

`define SSP_CFG0_RST 16'h0000
`define SSP_CFG1_RST 16'h0000

`define SSP_IN_SON 0
`define SSP_IN_OT  1
`define SSP_IN_PA  2
`define SSP_IN_PB  3
`define SSP_IN_MS  4
`define SSP_IN_FCL 5
`define SSP_IN_RCL 6
`endif

// [design/ssp_pkg.sv]
package ssp_pkg;
    typedef enum logic [2:0] {
        ST_OFF   = 3'h0,
        ST_RUN   = 3'h1,
        ST_DB    = 3'h2,
        ST_COAST = 3'h3,
        ST_PLUG  = 3'h4,
        ST_CLAMP = 3'h5
    } ssp_stop_t;

    typedef enum logic [2:0] {
        MD_SPD_ANALOG  = 3'h0,
        MD_POS_PULSE   = 3'h1,
        MD_TORQUE      = 3'h2,
        MD_SPD_CONTACT = 3'h3,
        MD_SPD_ZERO    = 3'h4
    } ssp_mode_t;

    typedef struct packed {
        logic [15:0] cfg0;
        logic [15:0] cfg1;
        logic [3:0]  stop_c;
        logic [3:0]  clr_c;
        logic [3:0]  fmt_c;
        logic [3:0]  inv_c;
        logic [3:0]  ff_c;
        logic [3:0]  mode_c;
        logic        load_pend;
        logic [6:0]  sy1;
        logic [6:0]  sy2;
        logic [6:0]  sy3;
        logic [6:0]  flt;
        ssp_stop_t   st;
        ssp_mode_t   mode;
        logic        p_only;
        logic        hs_ff;
        logic        ext_ff;
        logic        err_clr;
        logic        cnt_up;
        logic        cnt_dn;
        logic [15:0] count;
        logic [15:0] rdata;
    } ssp_state_t;
endpackage

// [design/ssp_top.sv]
`timescale 1ns/100ps
`include "ssp_cfg.svh"
module ssp_top (
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    input  wire logic [7:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output wire logic [15:0] RDATA,
    input  wire logic        RESTART,
    input  wire logic        SERVO_ON,
    input  wire logic        OVERTRAVEL,
    input  wire logic        MOTOR_STOPPED,
    input  wire logic        PULSE_TRAIN_INPUT,
    input  wire logic        SIGN_INPUT,
    input  wire logic        MODE_SWITCH_INPUT,
    input  wire logic        FORWARD_CURRENT_LIMIT_INPUT,
    input  wire logic        REVERSE_CURRENT_LIMIT_INPUT,
    output wire logic        DYNAMIC_BRAKE,
    output wire logic        DRIVE_ENABLE,
    output wire logic        PLUG_BRAKE,
    output wire logic        ZERO_CLAMP,
    output wire logic        ERROR_CLEAR,
    output wire logic        COUNT_UP,
    output wire logic        COUNT_DOWN,
    output wire logic [2:0]  CONTROL_MODE,
    output wire logic        P_ONLY,
    output wire logic        HIGH_SPEED_FF,
    output wire logic        EXT_FF_ENABLE
);

    ssp_pkg::ssp_state_t s_reg;
    ssp_pkg::ssp_state_t s_next;

    function automatic logic coast_on_off(input logic [3:0] c);
        coast_on_off = (c == 4'h1) || (c == 4'h3) || (c == 4'h5);
    endfunction

    function automatic logic plug_on_ot(input logic [3:0] c);
        plug_on_ot = (c >= 4'h2) && (c <= 4'h5);
    endfunction

    function automatic logic ends_in_clamp(input logic [3:0] c);
        ends_in_clamp = (c == 4'h4) || (c == 4'h5);
    endfunction

    logic [6:0] pins;
    assign pins = {REVERSE_CURRENT_LIMIT_INPUT, FORWARD_CURRENT_LIMIT_INPUT, MODE_SWITCH_INPUT,
                   SIGN_INPUT, PULSE_TRAIN_INPUT, OVERTRAVEL, SERVO_ON};

    logic son;
    logic ot;
    logic ms;
    logic all_off;
    assign son     = s_reg.flt[`SSP_IN_SON];
    assign ot      = s_reg.flt[`SSP_IN_OT];
    assign ms      = s_reg.flt[`SSP_IN_MS];
    assign all_off = !s_reg.flt[`SSP_IN_MS] && !s_reg.flt[`SSP_IN_FCL] && !s_reg.flt[`SSP_IN_RCL];

    always_comb begin
        logic [6:0] agree;
        logic       inv;
        logic       pa_p;
        logic       pb_p;
        logic       pa_c;
        logic       pb_c;
        logic       ea;
        logic       eb;
        logic       up;
        logic       dn;
        logic       fwd;
        agree = 7'h00;
        inv   = 1'b0;
        pa_p  = 1'b0;
        pb_p  = 1'b0;
        pa_c  = 1'b0;
        pb_c  = 1'b0;
        ea    = 1'b0;
        eb    = 1'b0;
        up    = 1'b0;
        dn    = 1'b0;
        fwd   = 1'b0;
        s_next = s_reg;
        s_next.rdata  = 16'h0000;
        s_next.cnt_up = 1'b0;
        s_next.cnt_dn = 1'b0;

        if (WR) begin
            case (ADDR)
                `SSP_ADDR_CFG0: s_next.cfg0 = WDATA;
                `SSP_ADDR_CFG1: s_next.cfg1 = WDATA;
                default: ;
            endcase
        end
        if (RD) begin
            case (ADDR)
                `SSP_ADDR_CFG0:   s_next.rdata = s_reg.cfg0;
                `SSP_ADDR_CFG1:   s_next.rdata = s_reg.cfg1;
                `SSP_ADDR_STATUS: s_next.rdata = {s_reg.mode_c, s_reg.stop_c, 1'b0, s_reg.mode, 1'b0, s_reg.st};
                `SSP_ADDR_COUNT:  s_next.rdata = s_reg.count;
                default:          s_next.rdata = 16'h0000;
            endcase
        end

        // codes act only from restart, so a half-written setup never steers a moving motor
        if (RESTART || s_reg.load_pend) begin // [RULE19]
            s_next.load_pend = 1'b0;
            s_next.stop_c    = s_reg.cfg0[`SSP_STOP_LSB +: 4];
            s_next.clr_c     = s_reg.cfg0[`SSP_CLR_LSB +: 4];
            s_next.fmt_c     = s_reg.cfg0[`SSP_FMT_LSB +: 4];
            s_next.inv_c     = s_reg.cfg0[`SSP_INV_LSB +: 4];
            s_next.ff_c      = s_reg.cfg1[`SSP_FF_LSB +: 4];
            s_next.mode_c    = s_reg.cfg1[`SSP_MODE_LSB +: 4];
        end

        // filtered level moves only where the second and third stage agree
        s_next.sy1 = pins;
        s_next.sy2 = s_reg.sy1;
        s_next.sy3 = s_reg.sy2;
        agree      = ~(s_reg.sy2 ^ s_reg.sy3);
        s_next.flt = (s_reg.flt & ~agree) | (s_reg.sy3 & agree);

        case (s_reg.st)
            ssp_pkg::ST_RUN: begin
                if (!son) begin
                    if (coast_on_off(s_reg.stop_c)) begin
                        s_next.st = ssp_pkg::ST_COAST; // [RULE2] [RULE4] [RULE6]
                    end else begin
                        s_next.st = ssp_pkg::ST_DB; // [RULE1] [RULE3] [RULE5]
                    end
                end else if (ot) begin
                    if (plug_on_ot(s_reg.stop_c)) begin
                        s_next.st = ssp_pkg::ST_PLUG; // [RULE3] [RULE4] [RULE5] [RULE6]
                    end else if (s_reg.stop_c == 4'h1) begin
                        s_next.st = ssp_pkg::ST_COAST; // [RULE2]
                    end else begin
                        s_next.st = ssp_pkg::ST_DB; // [RULE1]
                    end
                end
            end
            ssp_pkg::ST_DB: begin
                if (MOTOR_STOPPED) begin
                    s_next.st = ssp_pkg::ST_OFF; // [RULE1]
                end
            end
            ssp_pkg::ST_COAST: begin
                if (MOTOR_STOPPED) begin
                    s_next.st = ssp_pkg::ST_OFF;
                end
            end
            ssp_pkg::ST_PLUG: begin
                if (MOTOR_STOPPED) begin
                    if (ends_in_clamp(s_reg.stop_c)) begin
                        s_next.st = ssp_pkg::ST_CLAMP; // [RULE5] [RULE6]
                    end else begin
                        s_next.st = ssp_pkg::ST_OFF; // [RULE3] [RULE4]
                    end
                end
            end
            ssp_pkg::ST_CLAMP: begin
                if (!son) begin
                    s_next.st = ssp_pkg::ST_OFF;
                end else if (!ot) begin
                    s_next.st = ssp_pkg::ST_RUN;
                end
            end
            ssp_pkg::ST_OFF: begin
                if (son && !ot) begin
                    s_next.st = ssp_pkg::ST_RUN;
                end
            end
            default: s_next.st = ssp_pkg::ST_OFF;
        endcase

        case (s_reg.clr_c)
            4'h0:    s_next.err_clr = !son; // [RULE7]
            4'h2:    s_next.err_clr = !son || (ot && !ends_in_clamp(s_reg.stop_c)); // [RULE9]
            default: s_next.err_clr = 1'b0; // [RULE8]
        endcase

        s_next.p_only = 1'b0;
        case (s_reg.mode_c)
            4'h0: begin
                s_next.mode   = ssp_pkg::MD_SPD_ANALOG;
                s_next.p_only = ms; // [RULE13]
            end
            4'h1: begin
                s_next.mode   = ssp_pkg::MD_POS_PULSE;
                s_next.p_only = ms; // [RULE14]
            end
            4'h2: s_next.mode = ssp_pkg::MD_TORQUE; // [RULE15]
            4'h3: s_next.mode = all_off ? ssp_pkg::MD_SPD_ZERO : ssp_pkg::MD_SPD_CONTACT; // [RULE16]
            4'h4: s_next.mode = all_off ? ssp_pkg::MD_SPD_ANALOG : ssp_pkg::MD_SPD_CONTACT; // [RULE17]
            4'h5: s_next.mode = all_off ? ssp_pkg::MD_POS_PULSE : ssp_pkg::MD_SPD_CONTACT; // [RULE18]
            default: s_next.mode = ssp_pkg::MD_SPD_ANALOG;
        endcase

        s_next.hs_ff  = (s_reg.ff_c == 4'h2) || (s_reg.ff_c == 4'h3); // [RULE12]
        s_next.ext_ff = (s_reg.ff_c == 4'h1) || (s_reg.ff_c == 4'h3); // [RULE12]

        inv  = (s_reg.inv_c == 4'h2); // [RULE11]
        pa_p = s_reg.flt[`SSP_IN_PA] ^ inv;
        pb_p = s_reg.flt[`SSP_IN_PB] ^ inv;
        pa_c = s_next.flt[`SSP_IN_PA] ^ inv;
        pb_c = s_next.flt[`SSP_IN_PB] ^ inv;
        ea   = pa_p ^ pa_c;
        eb   = pb_p ^ pb_c;
        // a leads b: the new a differs from the old b
        fwd  = pa_c ^ pb_p;
        case (s_reg.fmt_c)
            4'h0: begin
                up = ea && pa_c && !pb_c; // [RULE10]
                dn = ea && pa_c && pb_c;
            end
            4'h1: begin
                up = ea && pa_c && !(eb && pb_c); // [RULE10]
                dn = eb && pb_c && !(ea && pa_c);
            end
            4'h2: begin
                up = ea && !eb && !pb_c && fwd; // [RULE10] [RULE20]
                dn = ea && !eb && !pb_c && !fwd;
            end
            4'h3: begin
                up = ea && !eb && fwd; // [RULE10] [RULE20]
                dn = ea && !eb && !fwd;
            end
            4'h4: begin
                up = (ea ^ eb) && fwd; // [RULE10] [RULE20]
                dn = (ea ^ eb) && !fwd;
            end
            default: begin
                up = 1'b0;
                dn = 1'b0;
            end
        endcase
        // pulses only steer the error count while position control is live
        s_next.cnt_up = up && (s_reg.mode == ssp_pkg::MD_POS_PULSE);
        s_next.cnt_dn = dn && (s_reg.mode == ssp_pkg::MD_POS_PULSE);

        if (s_next.err_clr) begin
            s_next.count = 16'h0000;
        end else if (s_next.cnt_up) begin
            s_next.count = s_reg.count + 16'h0001;
        end else if (s_next.cnt_dn) begin
            s_next.count = s_reg.count - 16'h0001;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_reg           <= '0;
            s_reg.cfg0      <= `SSP_CFG0_RST;
            s_reg.cfg1      <= `SSP_CFG1_RST;
            s_reg.load_pend <= 1'b1;
        end else if (CE) begin
            s_reg <= s_next;
        end
    end

    assign RDATA         = s_reg.rdata;
    assign DYNAMIC_BRAKE = (s_reg.st == ssp_pkg::ST_DB);
    assign PLUG_BRAKE    = (s_reg.st == ssp_pkg::ST_PLUG);
    assign ZERO_CLAMP    = (s_reg.st == ssp_pkg::ST_CLAMP);
    assign DRIVE_ENABLE  = (s_reg.st == ssp_pkg::ST_RUN) || PLUG_BRAKE || ZERO_CLAMP;
    assign ERROR_CLEAR   = s_reg.err_clr;
    assign COUNT_UP      = s_reg.cnt_up;
    assign COUNT_DOWN    = s_reg.cnt_dn;
    assign CONTROL_MODE  = s_reg.mode;
    assign P_ONLY        = s_reg.p_only;
    assign HIGH_SPEED_FF = s_reg.hs_ff;
    assign EXT_FF_ENABLE = s_reg.ext_ff;

    // phase changes as the decoder sees them; inversion cancels out of the xor
    logic a_chg;
    logic b_chg;
    assign a_chg = s_reg.flt[`SSP_IN_PA] ^ s_next.flt[`SSP_IN_PA];
    assign b_chg = s_reg.flt[`SSP_IN_PB] ^ s_next.flt[`SSP_IN_PB];

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    AST_STOP0_BRAKE: assert property ( // [RULE1]
        (CE && s_reg.st == ssp_pkg::ST_RUN && !son && s_reg.stop_c == 4'h0)
            |=> DYNAMIC_BRAKE ##0 (!CE || !MOTOR_STOPPED) [*1] or (CE && MOTOR_STOPPED) ##1 !DYNAMIC_BRAKE)
        else $error("stop code 0 did not brake then release");

    AST_STOP1_COAST: assert property ( // [RULE2]
        (s_reg.stop_c == 4'h1) |-> !DYNAMIC_BRAKE && !PLUG_BRAKE && !ZERO_CLAMP)
        else $error("stop code 1 used a brake or clamp");

    AST_OT_PLUG: assert property ( // [RULE3]
        (CE && s_reg.st == ssp_pkg::ST_RUN && son && ot && plug_on_ot(s_reg.stop_c)) |=> PLUG_BRAKE)
        else $error("overtravel did not start plug braking");

    AST_PLUG_OFF: assert property ( // [RULE4]
        (CE && PLUG_BRAKE && MOTOR_STOPPED && !ends_in_clamp(s_reg.stop_c)) |=> !DRIVE_ENABLE && !ZERO_CLAMP)
        else $error("plug stop did not end in coast");

    AST_PLUG_CLAMP: assert property ( // [RULE5]
        (CE && PLUG_BRAKE && MOTOR_STOPPED && ends_in_clamp(s_reg.stop_c)) |=> ZERO_CLAMP && DRIVE_ENABLE)
        else $error("plug stop did not end in zero clamp");

    AST_CLR0_KEEP_OT: assert property ( // [RULE7]
        (CE && s_reg.clr_c == 4'h0 && son) |=> !ERROR_CLEAR)
        else $error("clear code 0 cleared with servo on");

    AST_CLR1_NEVER: assert property ( // [RULE8]
        (CE && s_reg.clr_c == 4'h1) |=> !ERROR_CLEAR)
        else $error("clear code 1 cleared the error count");

    AST_CLR2_OT: assert property ( // [RULE9]
        (CE && s_reg.clr_c == 4'h2 && ot && !ends_in_clamp(s_reg.stop_c)) |=> ERROR_CLEAR && (s_reg.count == 16'h0000))
        else $error("clear code 2 kept the count on overtravel");

    AST_TORQUE_NO_P: assert property ( // [RULE15]
        (CE && s_reg.mode_c == 4'h2) |=> !P_ONLY && CONTROL_MODE == ssp_pkg::MD_TORQUE)
        else $error("torque mode reacted to the mode switch");

    AST_MODE4_ANALOG: assert property ( // [RULE17]
        (CE && s_reg.mode_c == 4'h4 && all_off) |=> CONTROL_MODE == ssp_pkg::MD_SPD_ANALOG)
        else $error("mode 4 did not change to analog speed");

    AST_CFG_HOLD: assert property ( // [RULE19]
        (CE && !RESTART && !s_reg.load_pend) |=> $stable(s_reg.stop_c) && $stable(s_reg.mode_c) && $stable(s_reg.fmt_c))
        else $error("active codes changed without restart");

    AST_QUAD_ILLEGAL: assert property ( // [RULE20]
        (CE && s_reg.fmt_c >= 4'h2 && s_reg.fmt_c <= 4'h4
            && (s_reg.flt[`SSP_IN_PA] != s_next.flt[`SSP_IN_PA])
            && (s_reg.flt[`SSP_IN_PB] != s_next.flt[`SSP_IN_PB])) |=> !COUNT_UP && !COUNT_DOWN)
        else $error("simultaneous phase change was counted");

    AST_OFF_COAST: assert property ( // [RULE6]
        (CE && s_reg.st == ssp_pkg::ST_RUN && !son && coast_on_off(s_reg.stop_c))
            |=> !DRIVE_ENABLE && !DYNAMIC_BRAKE)
        else $error("coast code braked or drove on servo off");

    AST_OFF_BRAKE: assert property ( // [RULE5]
        (CE && s_reg.st == ssp_pkg::ST_RUN && !son && !coast_on_off(s_reg.stop_c))
            |=> DYNAMIC_BRAKE && !DRIVE_ENABLE)
        else $error("brake code did not brake on servo off");

    AST_FMT0_UP: assert property ( // [RULE10]
        (CE && s_reg.fmt_c == 4'h0 && s_reg.inv_c == 4'h0 && s_reg.mode == ssp_pkg::MD_POS_PULSE
            && a_chg && s_next.flt[`SSP_IN_PA] && !s_next.flt[`SSP_IN_PB]) |=> COUNT_UP)
        else $error("pulse edge with sign low not counted up");

    AST_INV_CCW: assert property ( // [RULE11]
        (CE && s_reg.fmt_c == 4'h1 && s_reg.inv_c == 4'h2 && s_reg.mode == ssp_pkg::MD_POS_PULSE
            && !a_chg && b_chg && !s_next.flt[`SSP_IN_PB]) |=> COUNT_DOWN)
        else $error("inverted reverse pulse not counted down");

    AST_X4_COUNT: assert property ( // [RULE10]
        (CE && s_reg.fmt_c == 4'h4 && s_reg.mode == ssp_pkg::MD_POS_PULSE && (a_chg != b_chg))
            |=> COUNT_UP != COUNT_DOWN)
        else $error("single phase edge not counted once");

    AST_FF_HIGH_EXT: assert property ( // [RULE12]
        (CE && s_reg.ff_c == 4'h3) |=> HIGH_SPEED_FF && EXT_FF_ENABLE)
        else $error("feedforward code 3 not high speed with external input");

    AST_MODE0_P: assert property ( // [RULE13]
        (CE && s_reg.mode_c == 4'h0 && ms) |=> P_ONLY && CONTROL_MODE == ssp_pkg::MD_SPD_ANALOG)
        else $error("mode 0 switch on did not select proportional speed");

    AST_MODE1_PI: assert property ( // [RULE14]
        (CE && s_reg.mode_c == 4'h1 && !ms) |=> !P_ONLY && CONTROL_MODE == ssp_pkg::MD_POS_PULSE)
        else $error("mode 1 switch off did not select PI position");

    AST_MODE3_ZERO: assert property ( // [RULE16]
        (CE && s_reg.mode_c == 4'h3 && all_off) |=> CONTROL_MODE == ssp_pkg::MD_SPD_ZERO)
        else $error("mode 3 did not change to zero reference");

    AST_MODE5_PULSE: assert property ( // [RULE18]
        (CE && s_reg.mode_c == 4'h5 && all_off) |=> CONTROL_MODE == ssp_pkg::MD_POS_PULSE)
        else $error("mode 5 did not change to pulse position");

    AST_CONTACT_SPD: assert property ( // [RULE17]
        (CE && s_reg.mode_c >= 4'h3 && s_reg.mode_c <= 4'h5 && !all_off)
            |=> CONTROL_MODE == ssp_pkg::MD_SPD_CONTACT)
        else $error("contact speed not kept with an input on");

endmodule

// [tb/ssp_ctrl_model.sv]
`timescale 1ns/100ps
module ssp_ctrl_model #(
    parameter int HOLD = 6
) (
    input  wire logic clk,
    output logic      pulse_a,
    output logic      pulse_b,
    output logic      son,
    output logic      ot,
    output logic      ms,
    output logic      fcl,
    output logic      rcl
);
    logic inv_l;

    initial begin
        {pulse_a, pulse_b, son, ot, ms, fcl, rcl, inv_l} = '0;
    end

    // every level outlasts the pin filter, so no edge is swallowed
    task automatic step(input logic a, input logic b);
        @(posedge clk);
        pulse_a <= a ^ inv_l;
        pulse_b <= b ^ inv_l;
        repeat (HOLD - 1) @(posedge clk);
    endtask

    task automatic set_inv(input logic i);
        inv_l = i;
        step(1'b0, 1'b0);
    endtask

    task automatic pins(input logic [4:0] v);
        @(posedge clk);
        {son, ot, ms, fcl, rcl} <= v;
    endtask

    task automatic send(input int fmt, input logic up, input int n);
        for (int k = 0; k < n; k++) begin
            case (fmt)
                0: begin
                    step(1'b0, !up); // sign settles before the pulse edge
                    step(1'b1, !up);
                    step(1'b0, !up);
                end
                1: begin
                    step(up, !up); // separate up and down pulse lines
                    step(1'b0, 1'b0);
                end
                default: begin
                    step(up, !up); // phase a leads for up, b leads for down
                    step(1'b1, 1'b1);
                    step(!up, up);
                    step(1'b0, 1'b0);
                end
            endcase
        end
    endtask
endmodule

// [tb/tb_ssp_top.sv]
`timescale 1ns/100ps
module tb_ssp_top;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic [7:0]  addr    = 8'h00;
    logic [15:0] wdata   = 16'h0000;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic        rst_cfg = 1'b0;
    logic        stopped = 1'b0;
    logic        ce      = 1'b1;
    wire  logic [15:0] rdata;
    wire  logic [2:0]  cmode;
    wire  logic        pa, pb, son, ot, ms, fcl, rcl;
    wire  logic        db, de, pbk, zc, ec, cup, cdn, p_only, hs_ff, ext_ff;
    int          fails = 0;
    int          samples_checked = 0;
    int          seed = 47;
    int          n_up = 0;
    int          n_dn = 0;
    int          net = 0;
    int          u0, d0, n, e;
    logic [15:0] d, w;
    logic [2:0]  v;
    logic        up;

    always #2.5 ref_clk = ~ref_clk;

    // count pulses mid-cycle, away from the edge that launches them
    always @(negedge ref_clk) begin
        if (cup === 1'b1) n_up++;
        if (cdn === 1'b1) n_dn++;
    end

    ssp_top dut (.REF_CLK(ref_clk), .RST_N(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .RESTART(rst_cfg), .SERVO_ON(son), .OVERTRAVEL(ot), .MOTOR_STOPPED(stopped),
        .PULSE_TRAIN_INPUT(pa), .SIGN_INPUT(pb), .MODE_SWITCH_INPUT(ms), .FORWARD_CURRENT_LIMIT_INPUT(fcl),
        .REVERSE_CURRENT_LIMIT_INPUT(rcl), .DYNAMIC_BRAKE(db), .DRIVE_ENABLE(de), .PLUG_BRAKE(pbk),
        .ZERO_CLAMP(zc), .ERROR_CLEAR(ec), .COUNT_UP(cup), .COUNT_DOWN(cdn), .CONTROL_MODE(cmode),
        .P_ONLY(p_only), .HIGH_SPEED_FF(hs_ff), .EXT_FF_ENABLE(ext_ff));

    ssp_ctrl_model ctl (.clk(ref_clk), .pulse_a(pa), .pulse_b(pb), .son(son), .ot(ot), .ms(ms),
        .fcl(fcl), .rcl(rcl));

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [15:0] val);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= val;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [15:0] val);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        val = rdata;
    endtask

    task automatic do_restart;
        @(posedge ref_clk);
        rst_cfg <= 1'b1;
        @(posedge ref_clk);
        rst_cfg <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic configure(input logic [15:0] c0, input logic [15:0] c1);
        bus_wr(8'h00, c0);
        bus_wr(8'h04, c1);
        do_restart();
    endtask

    task automatic wait_de;
        int k;
        for (k = 0; k < 20 && de !== 1'b1; k++) @(negedge ref_clk);
        if (k == 20) begin
            fails++;
            $display("[FAIL] drive enable expected 1 seen %b", de);
            summarize();
        end
    endtask

    function automatic logic [15:0] exp_mode(input int m, input logic [2:0] pins);
        if (m < 3) return 16'(m);
        if (pins != 3'b000) return 16'h0003;
        return (m == 3) ? 16'h0004 : (m == 4) ? 16'h0000 : 16'h0001;
    endfunction

    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        chk("mode after reset", 16'h0000, 16'(cmode));
        bus_rd(8'h00, d);
        chk("cfg0 reset", 16'h0000, d);
        bus_rd(8'h04, d);
        chk("cfg1 reset", 16'h0000, d);
        bus_wr(8'h10, 16'hFFFF);
        bus_rd(8'h10, d);
        chk("unmapped read", 16'h0000, d);
        @(negedge ref_clk);
        chk("rdata after read cycle", 16'h0000, rdata);
        for (int m = 0; m < 6; m++) begin
            for (int r = 0; r < 4; r++) begin
                v = (r == 0) ? 3'b000 : 3'($random(seed));
                w = {8'($random(seed)), 4'(m), 4'(r)};
                ctl.pins({2'b00, v});
                configure(16'h0010, w);
                repeat (8) @(posedge ref_clk);
                @(negedge ref_clk);
                chk("control mode", exp_mode(m, v), 16'(cmode));
                if (m < 3) chk("p only", 16'((m < 2) && v[2]), 16'(p_only));
                chk("high speed ff", 16'(r >= 2), 16'(hs_ff));
                chk("ext ff enable", 16'(r % 2), 16'(ext_ff));
                bus_rd(8'h04, d);
                chk("cfg1 readback", w, d);
                bus_rd(8'h08, d);
                chk("status mode code", 16'(m), 16'(d[15:12]));
            end
        end
        ctl.pins(5'b00000);
        repeat (8) @(posedge ref_clk);
        bus_wr(8'h04, 16'h0020);
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("mode before restart", 16'h0001, 16'(cmode));
        do_restart();
        @(negedge ref_clk);
        chk("mode after restart", 16'h0002, 16'(cmode));
        for (int s = 0; s < 6; s++) begin
            for (int p = 0; p < 2; p++) begin
                for (int c = 0; c < 3; c++) begin
                    configure({8'h00, 4'(c), 4'(s)}, 16'h0010);
                    ctl.pins(5'b10000);
                    wait_de();
                    // overtravel keeps servo on; otherwise servo goes off
                    ctl.pins(p ? 5'b11000 : 5'b00000);
                    repeat (8) @(posedge ref_clk);
                    @(negedge ref_clk);
                    chk("dyn brake", 16'(p ? (s == 0) : (s % 2 == 0)), 16'(db));
                    chk("plug brake", 16'(p && s >= 2), 16'(pbk));
                    chk("drive enable", 16'(p && s >= 2), 16'(de));
                    e = (c == 0) ? !p : (c == 2) ? (!p || s < 4) : 0;
                    chk("error clear", 16'(e), 16'(ec));
                    @(posedge ref_clk);
                    stopped <= 1'b1;
                    repeat (3) @(posedge ref_clk);
                    @(negedge ref_clk);
                    chk("zero clamp", 16'(p && s >= 4), 16'(zc));
                    chk("brake released", 16'h0000, 16'({db, pbk}));
                    ctl.pins(5'b00000);
                    repeat (8) @(posedge ref_clk);
                    stopped <= 1'b0;
                end
            end
        end
        for (int f = 0; f < 5; f++) begin
            for (int i = 0; i < 2; i++) begin
                configure({4'(2 * i), 4'(f), 8'h10}, 16'h0010);
                ctl.set_inv(1'(i));
                repeat (8) @(posedge ref_clk);
                u0 = n_up;
                d0 = n_dn;
                n = 1 + ($random(seed) & 3);
                up = 1'($random(seed));
                ctl.send(f, up, n);
                repeat (8) @(posedge ref_clk);
                e = n * ((f == 3) ? 2 : (f == 4) ? 4 : 1);
                net = net + (up ? e : -e);
                chk("count up", 16'(up ? e : 0), 16'(n_up - u0));
                chk("count down", 16'(up ? 0 : e), 16'(n_dn - d0));
            end
        end
        // both phases flipping together carries no direction
        u0 = n_up;
        d0 = n_dn;
        ctl.step(1'b1, 1'b1);
        ctl.step(1'b0, 1'b0);
        repeat (8) @(posedge ref_clk);
        chk("joint edge count", 16'h0000, 16'((n_up - u0) + (n_dn - d0)));
        // clear code 1 kept every pulse since the last stop cleared the count
        bus_rd(8'h0C, d);
        chk("error count", 16'(net), d);
        // enable low: a write must not land
        @(posedge ref_clk);
        ce <= 1'b0;
        bus_wr(8'h04, 16'hABCD);
        ce <= 1'b1;
        bus_rd(8'h04, d);
        chk("cfg1 frozen", 16'h0010, d);
        summarize();
    end
endmodule
